// file: include/atdsl_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 delayed conversion trigger block. Assumes inclusion by bare name.
*/
`ifndef ATDSL_MAP_SVH
`define ATDSL_MAP_SVH
`define ATDSL_OFF_CTRL       12'h000
`define ATDSL_OFF_PERIOD     12'h004
`define ATDSL_OFF_DUTY_BUF   12'h008
`define ATDSL_OFF_DELAY_A    12'h00C
`define ATDSL_OFF_SKIP_CFG   12'h010
`define ATDSL_OFF_STATUS     12'h014
`define ATDSL_OFF_IRQ_EN     12'h018
`define ATDSL_OFF_IRQ_CLR    12'h01C
`define ATDSL_OFF_COUNT      12'h020
`define ATDSL_CTRL_RUN       0
`define ATDSL_CTRL_LINK_TRGH 1
`define ATDSL_SKIP_CNT_LSB   0
`define ATDSL_SKIP_VALID     3'h2
`define ATDSL_RST_PERIOD     16'h52D0
`define ATDSL_RST_DUTY       16'h3E80
`define ATDSL_RST_DELAY_A    16'h4650
`define ATDSL_RST_SKIP       3'h2
`define ATDSL_PRESCALE_DIV   4
`define ATDSL_ST_TRIG        0
`define ATDSL_ST_PEAK        1
`define ATDSL_ST_TROUGH      2
`define ATDSL_ST_SUPPR       3
`endif

// file: include/atdsl_pkg.sv
/*
 Types of the delayed conversion trigger block.
 Assumes nothing of its surroundings.
*/
package atdsl_pkg;
    typedef enum logic [0:0] {
        ATDSL_DIR_UP   = 1'b0,
        ATDSL_DIR_DOWN = 1'b1
    } atdsl_dir_e;

    typedef struct packed {
        logic        link_trough;
        logic [2:0]  skip_count;
        logic [15:0] period;
        logic [15:0] duty;
        logic [15:0] delay_a;
    } atdsl_cfg_s;

    typedef logic [3:0] atdsl_evt_t;
endpackage : atdsl_pkg

// file: tb/atdsl_conv_model.sv
/*
 Converter start input: counts accepted start pulses.
 Assumes the one-cycle registered trigger of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module atdsl_conv_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start_trig,
    output var int   starts
);
    // Each sampled pulse starts one conversion
    always_ff @(posedge aclk)
    begin
        if (!aresetn) starts <= 0;
        else if (start_trig === 1'b1) starts <= starts + 1;
    end
endmodule : atdsl_conv_model
`default_nettype wire

// file: tb/atdsl_top_asserts.sv
/*
 Port checker of the delayed trigger block.
 Assumes the bind below onto atdsl_top.
*/
`timescale 1ns/1ps
`default_nettype none
module atdsl_top_chk
    import atdsl_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        pwm_pos_r,
    input wire logic        pwm_neg_r,
    input wire logic        trigger_monitor_pin,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    trig_space_a: assert property (trigger_monitor_pin |=> !trigger_monitor_pin [*3])
        else $error("trigger pulses closer than one timer step");
    pwm_compl_a: assert property (pwm_neg_r == !pwm_pos_r)
        else $error("phases not complementary");
    reset_out_a: assert property (disable iff (1'b0) !aresetn |=>
        pwm_pos_r && !pwm_neg_r && !trigger_monitor_pin && !irq) else $error("bad reset level");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while answer pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    trig_c: cover property (trigger_monitor_pin);
    irq_c: cover property (irq);
    err_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : atdsl_top_chk
bind atdsl_top atdsl_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pwm_pos_r, .pwm_neg_r,
    .trigger_monitor_pin, .irq);
`default_nettype wire

// file: tb/atdsl_top_tb.sv
/*
 Self-checking bench of the delayed trigger block.
 Assumes atdsl_top, its checker and the converter model.
*/
`include "atdsl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module atdsl_top_tb;
    logic aclk = 0, aresetn = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pos, neg, trig, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] val;
    int bad_count = 0, n_checks = 0, cyc = 0, starts, c0;
    always #2 aclk = ~aclk;
    atdsl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwm_pos_r(pos), .pwm_neg_r(neg),
        .trigger_monitor_pin(trig), .irq(irq));
    atdsl_conv_model u_conv (.aclk(aclk), .aresetn(aresetn), .start_trig(trig),
        .starts(starts));
    task automatic close_out();
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            bad_count = bad_count + 1;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        resp = bresp;
        bready <= 0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        val = rdata; resp = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask : rd
    task automatic reg_reset();
        rd(`ATDSL_OFF_PERIOD); chk("period", val, 32'h52D0);
        rd(`ATDSL_OFF_DUTY_BUF); chk("duty", val, 32'h3E80);
        rd(`ATDSL_OFF_DELAY_A); chk("delay", val, 32'h4650);
        rd(`ATDSL_OFF_SKIP_CFG); chk("skip", val, 32'h2);
        rd(`ATDSL_OFF_IRQ_CLR); chk("clr_rresp", resp, 2'h2);
        wr(12'h040, 32'h1); chk("unmapped_bresp", resp, 2'h2);
        chk("pos_idle", pos, 1'b1);
    endtask : reg_reset
    // Nine carriers of 320 cycles each from a fresh start
    task automatic run_case(input logic [31:0] ctl, input logic [31:0] skp, input int exp);
        wr(`ATDSL_OFF_CTRL, 32'h0);
        wr(`ATDSL_OFF_SKIP_CFG, skp);
        c0 = starts;
        wr(`ATDSL_OFF_CTRL, ctl);
        repeat (3000) @(posedge aclk);
        chk("starts", starts - c0, exp);
    endtask : run_case
    task automatic irq_case();
        wr(`ATDSL_OFF_IRQ_EN, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq_on", irq, 1'b1);
        wr(`ATDSL_OFF_CTRL, 32'h0);
        rd(`ATDSL_OFF_STATUS); chk("status", val, 32'hF);
        wr(`ATDSL_OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq_mask", irq, 1'b0);
        wr(`ATDSL_OFF_IRQ_CLR, 32'hF);
        rd(`ATDSL_OFF_STATUS); chk("cleared", val, 32'h0);
    endtask : irq_case
    // Duty change mid-carrier takes effect only after the trough
    task automatic pwm_case();
        wr(`ATDSL_OFF_CTRL, 32'h0);
        wr(`ATDSL_OFF_CTRL, 32'h1);
        repeat (56) @(posedge aclk);
        chk("pos_start", pos, 1'b1);
        repeat (90) @(posedge aclk);
        chk("pos_up", pos, 1'b0);
        chk("neg_up", neg, 1'b1);
        wr(`ATDSL_OFF_DUTY_BUF, 32'd10);
        repeat (106) @(posedge aclk);
        chk("pos_down", pos, 1'b1);
        repeat (130) @(posedge aclk);
        chk("pos_new_duty", pos, 1'b0);
    endtask : pwm_case
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        reg_reset();
        wr(`ATDSL_OFF_PERIOD, 32'd40);
        wr(`ATDSL_OFF_DUTY_BUF, 32'd20);
        wr(`ATDSL_OFF_DELAY_A, 32'd30);
        run_case(32'h1, 32'h2, 3);
        irq_case();
        run_case(32'h3, 32'h2, 3);
        run_case(32'h1, 32'h0, 9);
        pwm_case();
        close_out();
    end
endmodule : atdsl_top_tb
`default_nettype wire

// file: verilog/atdsl_top.sv
/*
 Complementary PWM pair with a delayed conversion start trigger gated by
 peak or trough interrupt skipping, registers on AXI4-Lite.
 Assumes aclk at 250 MHz and a converter that samples the trigger pulse.
*/
`include "atdsl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module atdsl_top
    import atdsl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             pwm_pos_r,
    output logic             pwm_neg_r,
    output logic             trigger_monitor_pin,
    output logic             irq
);
    atdsl_cfg_s  cfg_r;
    logic        run_r;
    logic [1:0]  pre_r;
    logic        tick;
    logic [15:0] timer_count;
    atdsl_dir_e  dir_r;
    logic [15:0] duty_act_r;
    logic [2:0]  peak_skip_counter;
    logic [2:0]  trough_skip_counter;
    logic        peak_compare_irq;
    logic        trough_underflow_irq;
    logic        delay_match;
    logic        trig_ok;
    atdsl_evt_t  status_r;
    atdsl_evt_t  irq_en_r;
    atdsl_evt_t  evt;
    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_go;
    logic        ar_go;
    logic [31:0] rd_word;
    logic        clr_pulse;
    atdsl_evt_t  clr_mask;

    // Byte lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // Skip counter step: wraps back to zero after reaching the configured count
    function automatic logic [2:0] skip_step(input logic [2:0] c, input logic [2:0] lim);
        skip_step = (c >= lim) ? 3'h0 : 3'(c + 3'h1);
    endfunction : skip_step

    // Prescaler, one timer step per four clock ticks
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_r)
            pre_r <= 2'h0;
        else
            pre_r <= 2'(pre_r + 2'h1);
    end
    assign tick = run_r && (pre_r == 2'(`ATDSL_PRESCALE_DIV - 1));

    // Up/down counter between zero and the period, cleared while stopped
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_r)
        begin
            timer_count <= 16'h0000;
            dir_r       <= ATDSL_DIR_UP;
        end
        else if (tick)
        begin
            if (dir_r == ATDSL_DIR_UP)
            begin
                if (timer_count >= cfg_r.period)
                begin
                    dir_r       <= ATDSL_DIR_DOWN;
                    timer_count <= 16'(timer_count - 16'h0001);
                end
                else
                    timer_count <= 16'(timer_count + 16'h0001);
            end
            else if (timer_count == 16'h0000)
            begin
                dir_r       <= ATDSL_DIR_UP;
                timer_count <= 16'h0001;
            end
            else
                timer_count <= 16'(timer_count - 16'h0001);
        end
    end

    assign peak_compare_irq     = tick && dir_r == ATDSL_DIR_UP && timer_count >= cfg_r.period;
    assign trough_underflow_irq = tick && dir_r == ATDSL_DIR_DOWN && timer_count == 16'h0000;

    // Duty transfer only at the trough
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            duty_act_r <= `ATDSL_RST_DUTY;
        else if (trough_underflow_irq)
            duty_act_r <= cfg_r.duty;
    end

    // Complementary outputs, active low, pwm_pos_r initial high and pwm_neg_r initial low
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_r)
        begin
            pwm_pos_r <= 1'b1;
            pwm_neg_r <= 1'b0;
        end
        else if (tick && timer_count == duty_act_r)
        begin
            pwm_pos_r <= (dir_r == ATDSL_DIR_DOWN);
            pwm_neg_r <= (dir_r == ATDSL_DIR_UP);
        end
    end

    // Skip counters for peak and trough interrupts
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_r)
        begin
            peak_skip_counter   <= 3'h0;
            trough_skip_counter <= 3'h0;
        end
        else
        begin
            if (peak_compare_irq)
                peak_skip_counter <= skip_step(peak_skip_counter, cfg_r.skip_count);
            if (trough_underflow_irq)
                trough_skip_counter <= skip_step(trough_skip_counter, cfg_r.skip_count);
        end
    end

    assign delay_match = tick && dir_r == ATDSL_DIR_UP && timer_count == cfg_r.delay_a;
    assign trig_ok = cfg_r.link_trough ? (trough_skip_counter == cfg_r.skip_count)
                                       : (peak_skip_counter == cfg_r.skip_count);

    // Trigger pulse toward the converter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            trigger_monitor_pin <= 1'b0;
        else
            trigger_monitor_pin <= delay_match && trig_ok;
    end

    assign evt = {delay_match && !trig_ok, trough_underflow_irq, peak_compare_irq,
                  delay_match && trig_ok};

    // Sticky status, set wins over clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status_r <= 4'h0;
        else
            status_r <= (status_r & ~(clr_pulse ? clr_mask : 4'h0)) | evt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(status_r & irq_en_r);
    end

    // AXI4-Lite write channel capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 12'h000;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held_r <= 1'b0;
        end
    end

    assign wr_go     = aw_held_r && w_held_r && !s_axi_bvalid;
    assign clr_pulse = wr_go && awaddr_r == `ATDSL_OFF_IRQ_CLR && wstrb_r[0];
    assign clr_mask  = wdata_r[3:0];
    assign ar_go     = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r > `ATDSL_OFF_IRQ_CLR || awaddr_r[1:0] != 2'h0)
                                ? 2'h2 : 2'h0;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_r            <= 1'b0;
            cfg_r.link_trough <= 1'b0;
            cfg_r.skip_count <= `ATDSL_RST_SKIP;
            cfg_r.period     <= `ATDSL_RST_PERIOD;
            cfg_r.duty       <= `ATDSL_RST_DUTY;
            cfg_r.delay_a    <= `ATDSL_RST_DELAY_A;
            irq_en_r         <= 4'h0;
        end
        else if (wr_go)
        begin
            unique case (awaddr_r)
                `ATDSL_OFF_CTRL:
                    if (wstrb_r[0])
                    begin
                        run_r             <= wdata_r[`ATDSL_CTRL_RUN];
                        cfg_r.link_trough <= wdata_r[`ATDSL_CTRL_LINK_TRGH];
                    end
                `ATDSL_OFF_PERIOD:   cfg_r.period  <= merge16(cfg_r.period, wdata_r, wstrb_r);
                `ATDSL_OFF_DUTY_BUF: cfg_r.duty    <= merge16(cfg_r.duty, wdata_r, wstrb_r);
                `ATDSL_OFF_DELAY_A:  cfg_r.delay_a <= merge16(cfg_r.delay_a, wdata_r, wstrb_r);
                `ATDSL_OFF_SKIP_CFG:
                    if (wstrb_r[0])
                        cfg_r.skip_count <= wdata_r[`ATDSL_SKIP_CNT_LSB +: 3];
                `ATDSL_OFF_IRQ_EN:
                    if (wstrb_r[0])
                        irq_en_r <= wdata_r[3:0];
                default: ;
            endcase
        end
    end

    // Read data mux
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            `ATDSL_OFF_CTRL:     rd_word = {30'h0, cfg_r.link_trough, run_r};
            `ATDSL_OFF_PERIOD:   rd_word = {16'h0, cfg_r.period};
            `ATDSL_OFF_DUTY_BUF: rd_word = {16'h0, cfg_r.duty};
            `ATDSL_OFF_DELAY_A:  rd_word = {16'h0, cfg_r.delay_a};
            `ATDSL_OFF_SKIP_CFG: rd_word = {29'h0, cfg_r.skip_count};
            `ATDSL_OFF_STATUS:   rd_word = {28'h0, status_r};
            `ATDSL_OFF_IRQ_EN:   rd_word = {28'h0, irq_en_r};
            `ATDSL_OFF_COUNT:    rd_word = {7'h0, dir_r, peak_skip_counter, trough_skip_counter,
                                            2'h0, timer_count};
            default:             rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !ar_go && !s_axi_arready;
            if (ar_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= (s_axi_araddr > `ATDSL_OFF_COUNT || s_axi_araddr[1:0] != 2'h0
                                 || s_axi_araddr == `ATDSL_OFF_IRQ_CLR) ? 2'h2 : 2'h0;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : atdsl_top

`default_nettype wire
